// ### hw/lsl_cfg_if.sv
// Purpose: Carrier between the register front end and the lane storage
// Assumes: One write port with a lane mask, one registered read port
// Notes: Storage words are visible in parallel for the lane outputs
`timescale 1ns/1ps
`default_nettype none
interface lsl_cfg_if #(parameter int LANES = lsl_pkg::LANE_CNT);
  logic [LANES-1:0] wr_lane_mask;
  logic wr_reg;
  logic [lsl_pkg::DATA_W-1:0] wr_data;
  logic [lsl_pkg::SEL_W-1:0] rd_lane;
  logic rd_reg;
  logic [lsl_pkg::DATA_W-1:0] rd_data;
  logic [LANES-1:0][lsl_pkg::DATA_W-1:0] cfg_a;
  logic [LANES-1:0][lsl_pkg::DATA_W-1:0] cfg_b;

  modport ctrl (
    output wr_lane_mask, wr_reg, wr_data, rd_lane, rd_reg,
    input rd_data, cfg_a, cfg_b
  );
  modport mem (
    input wr_lane_mask, wr_reg, wr_data, rd_lane, rd_reg,
    output rd_data, cfg_a, cfg_b
  );
endinterface
`default_nettype wire

// ### hw/lsl_lane_cfg.sv
// Purpose: Per-lane low-speed serdes configuration bank and PLL code decode
// Assumes: Register strobes, lane select and power-down pins are synchronous
// Notes: Lane outputs lag the stored words and the pins by one clock
//
// What this block does
// R01: Decode the 4-bit PLL multiplier code; unlisted codes flagged reserved.
// R02: Hold 3-bit output amplitude per lane in bits 14:12, reset 101.
// R03: Bit 11 enables loss-of-signal detection per lane, reset 1.
// R04: Bit 10 enables transmit lane; power-down pin or global down forces off.
// R05: Bit 2 enables receive lane; power-down pin or global down forces off.
// R06: Bits 9:8 set transmit rate full, half, quarter; 11 reserved.
// R07: Bits 1:0 set receive rate with the same encoding; 11 reserved.
// R08: Hold 4-bit de-emphasis code in bits 7:4, reset zero.
// R09: Second word bit 15 swaps receive output polarity.
// R10: Second word bit 14 inverts transmit input polarity.
// R11: Decode equalizer bits 11:8: max gain, adaptive, reserved, stepped zero.
// R12: Second word bits 7:0 are plain storage resetting to 00001101.
// R13: Global write updates all lanes; otherwise only the selected lane.
// R14: Each lane keeps its own copy; reads return the selected lane.
`timescale 1ns/1ps
`default_nettype none
module lsl_lane_cfg #(
  parameter int LANES = lsl_pkg::LANE_CNT
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [lsl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [lsl_pkg::DATA_W-1:0] reg_wdata,
  output logic [lsl_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rd_valid,
  input wire logic all_lanes_write_en,
  input wire logic [lsl_pkg::SEL_W-1:0] lane_select,
  input wire logic global_power_down,
  input wire logic [LANES-1:0] lane_power_down_n,
  input wire logic [3:0] slow_pll_multiplier_code,
  output logic [7:0] pll_multiplier_halves,
  output logic pll_multiplier_reserved,
  output logic [LANES-1:0] lane_tx_channel_enable,
  output logic [LANES-1:0] lane_rx_channel_enable,
  output logic [2*LANES-1:0] lane_tx_rate_divide,
  output logic [2*LANES-1:0] lane_rx_rate_divide,
  output logic [LANES-1:0] lane_rate_reserved,
  output logic [3*LANES-1:0] lane_output_amplitude,
  output logic [LANES-1:0] lane_signal_loss_detect_en,
  output logic [4*LANES-1:0] lane_deemphasis_code,
  output logic [LANES-1:0] lane_rx_polarity_swap,
  output logic [LANES-1:0] lane_tx_polarity_swap,
  output logic [4*LANES-1:0] lane_equalizer_code,
  output logic [LANES-1:0] lane_eq_max_gain,
  output logic [LANES-1:0] lane_eq_adaptive,
  output logic [LANES-1:0] lane_eq_reserved,
  output logic [10:0] sel_amplitude_mv,
  output logic [12:0] sel_deemph_centipct,
  output logic [8:0] sel_eq_zero_mhz
);
  import lsl_pkg::*;

  if (LANES < 1 || LANES > (1 << SEL_W)) begin : g_lane_check
    $error("LANES must lie between 1 and 8");
  end

  // Multiplier in half steps so that 12.5x stays exact
  function automatic logic [7:0] mult_halves(input logic [3:0] code);
    case (code)
      4'h0: mult_halves = 8'h08;
      4'h1: mult_halves = 8'h0A;
      4'h2: mult_halves = 8'h0C;
      4'h4: mult_halves = 8'h10;
      4'h5: mult_halves = 8'h14;
      4'h6: mult_halves = 8'h18;
      4'h7: mult_halves = 8'h19;
      4'h8: mult_halves = 8'h1E;
      4'h9: mult_halves = 8'h28;
      4'hA: mult_halves = 8'h32;
      4'hD: mult_halves = 8'h64;
      4'hE: mult_halves = 8'h82;
      default: mult_halves = MULT_RESERVED;
    endcase
  endfunction

  // Typical differential peak-to-peak swing
  function automatic logic [10:0] amp_mv(input logic [2:0] code);
    case (code)
      3'h0: amp_mv = 11'h0BE;
      3'h1: amp_mv = 11'h17C;
      3'h2: amp_mv = 11'h230;
      3'h3: amp_mv = 11'h2C6;
      3'h4: amp_mv = 11'h352;
      3'h5: amp_mv = 11'h3B6;
      3'h6: amp_mv = 11'h3F2;
      default: amp_mv = 11'h41A;
    endcase
  endfunction

  // Amplitude reduction in hundredths of a percent
  function automatic logic [12:0] deemph_centipct(input logic [3:0] code);
    case (code)
      4'h0: deemph_centipct = 13'h0000;
      4'h1: deemph_centipct = 13'h01DC;
      4'h2: deemph_centipct = 13'h03B8;
      4'h3: deemph_centipct = 13'h0594;
      4'h4: deemph_centipct = 13'h0770;
      4'h5: deemph_centipct = 13'h094C;
      4'h6: deemph_centipct = 13'h0B28;
      4'h7: deemph_centipct = 13'h0D04;
      4'h8: deemph_centipct = 13'h0EE0;
      4'h9: deemph_centipct = 13'h10BD;
      4'hA: deemph_centipct = 13'h1299;
      4'hB: deemph_centipct = 13'h1476;
      4'hC: deemph_centipct = 13'h1652;
      4'hD: deemph_centipct = 13'h182E;
      4'hE: deemph_centipct = 13'h1A0A;
      default: deemph_centipct = 13'h1BE6;
    endcase
  endfunction

  // Zero frequency of the stepped adaptive range; zero outside it
  function automatic logic [8:0] eq_zero_mhz(input logic [3:0] code);
    case (code)
      4'h8: eq_zero_mhz = 9'h16D;
      4'h9: eq_zero_mhz = 9'h113;
      4'hA: eq_zero_mhz = 9'h0C3;
      4'hB: eq_zero_mhz = 9'h08C;
      4'hC: eq_zero_mhz = 9'h069;
      4'hD: eq_zero_mhz = 9'h04B;
      4'hE: eq_zero_mhz = 9'h037;
      4'hF: eq_zero_mhz = 9'h032;
      default: eq_zero_mhz = 9'h000;
    endcase
  endfunction

  lsl_cfg_if #(.LANES(LANES)) mem_if ();

  lsl_lane_mem #(.LANES(LANES)) u_mem (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .cfg(mem_if.mem)
  );

  // Register decode
  wire hit_a = (reg_addr == ADDR_RATE_ENABLE);
  wire hit_b = (reg_addr == ADDR_POLARITY_EQ);
  wire sel_valid = (32'(lane_select) < LANES);
  wire wr_hit = reg_wr_en && (hit_a || hit_b);
  wire rd_hit = reg_rd_en && (hit_a || hit_b) && sel_valid;
  wire [LANES-1:0] one_lane = {{(LANES-1){1'b0}}, 1'b1} << lane_select;
  wire [LANES-1:0] lane_mask = all_lanes_write_en ? {LANES{1'b1}} :  // see R13
                               (sel_valid ? one_lane : {LANES{1'b0}});

  assign mem_if.wr_lane_mask = wr_hit ? lane_mask : {LANES{1'b0}};  // see R13
  assign mem_if.wr_reg = hit_b;
  assign mem_if.wr_data = reg_wdata;
  // Out-of-range select reads lane 0 internally, but the answer is forced to zero
  assign mem_if.rd_lane = sel_valid ? lane_select : '0;  // see R14
  assign mem_if.rd_reg = hit_b;

  logic rd_stage;
  logic rd_stage_hit;

  // Lane decode into next values
  logic [LANES-1:0] next_tx_en;
  logic [LANES-1:0] next_rx_en;
  logic [2*LANES-1:0] next_tx_rate;
  logic [2*LANES-1:0] next_rx_rate;
  logic [LANES-1:0] next_rate_rsvd;
  logic [3*LANES-1:0] next_amp;
  logic [LANES-1:0] next_los;
  logic [4*LANES-1:0] next_de;
  logic [LANES-1:0] next_rx_swap;
  logic [LANES-1:0] next_tx_swap;
  logic [4*LANES-1:0] next_eq;
  logic [LANES-1:0] next_eq_max;
  logic [LANES-1:0] next_eq_adapt;
  logic [LANES-1:0] next_eq_rsvd;

  for (genvar l = 0; l < LANES; l++) begin : g_lane
    wire [DATA_W-1:0] wa = mem_if.cfg_a[l];
    wire [DATA_W-1:0] wb = mem_if.cfg_b[l];
    wire lane_up = lane_power_down_n[l] && !global_power_down;
    wire [3:0] eq = wb[EQ_MSB:EQ_LSB];
    assign next_tx_en[l] = wa[TXEN_BIT] && lane_up;  // see R04
    assign next_rx_en[l] = wa[RXEN_BIT] && lane_up;  // see R05
    assign next_tx_rate[2*l+:2] = wa[TXRATE_MSB:TXRATE_LSB];  // see R06
    assign next_rx_rate[2*l+:2] = wa[RXRATE_MSB:RXRATE_LSB];  // see R07
    assign next_rate_rsvd[l] = (wa[TXRATE_MSB:TXRATE_LSB] == RATE_RESERVED) ||
                               (wa[RXRATE_MSB:RXRATE_LSB] == RATE_RESERVED);
    assign next_amp[3*l+:3] = wa[AMP_MSB:AMP_LSB];  // see R02
    assign next_los[l] = wa[LOS_BIT];  // see R03
    assign next_de[4*l+:4] = wa[DE_MSB:DE_LSB];  // see R08
    assign next_rx_swap[l] = wb[RXSWAP_BIT];  // see R09
    assign next_tx_swap[l] = wb[TXSWAP_BIT];  // see R10
    assign next_eq[4*l+:4] = eq;
    assign next_eq_max[l] = (eq == EQ_MAX_GAIN);  // see R11
    assign next_eq_adapt[l] = (eq == EQ_ADAPTIVE) || (eq >= EQ_STEP_FIRST);  // see R11
    assign next_eq_rsvd[l] = (eq > EQ_ADAPTIVE) && (eq < EQ_STEP_FIRST);  // see R11
  end

  // Readout of the selected lane in physical units
  wire [DATA_W-1:0] sel_a = mem_if.cfg_a[mem_if.rd_lane];
  wire [DATA_W-1:0] sel_b = mem_if.cfg_b[mem_if.rd_lane];
  wire [10:0] next_sel_amp = amp_mv(sel_a[AMP_MSB:AMP_LSB]);
  wire [12:0] next_sel_de = deemph_centipct(sel_a[DE_MSB:DE_LSB]);
  wire [8:0] next_sel_eq = eq_zero_mhz(sel_b[EQ_MSB:EQ_LSB]);
  wire [7:0] next_mult = mult_halves(slow_pll_multiplier_code);  // see R01

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rd_stage <= 1'b0;
      rd_stage_hit <= 1'b0;
      reg_rd_valid <= 1'b0;
      reg_rdata <= '0;
    end else begin
      rd_stage <= reg_rd_en;
      rd_stage_hit <= rd_hit;
      reg_rd_valid <= rd_stage;
      // Unmapped address or absent lane answers zero
      reg_rdata <= rd_stage_hit ? mem_if.rd_data : '0;  // see R14
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pll_multiplier_halves <= MULT_RESERVED;
      pll_multiplier_reserved <= 1'b1;
      sel_amplitude_mv <= '0;
      sel_deemph_centipct <= '0;
      sel_eq_zero_mhz <= '0;
    end else begin
      pll_multiplier_halves <= next_mult;
      pll_multiplier_reserved <= (next_mult == MULT_RESERVED);  // see R01
      sel_amplitude_mv <= next_sel_amp;
      sel_deemph_centipct <= next_sel_de;
      sel_eq_zero_mhz <= next_sel_eq;
    end
  end

  // Reset images follow the stored defaults, except the channel enables, which reset low and rise after release
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      lane_tx_channel_enable <= '0;
      lane_rx_channel_enable <= '0;
      lane_tx_rate_divide <= {LANES{RATE_HALF}};
      lane_rx_rate_divide <= {LANES{RATE_HALF}};
      lane_rate_reserved <= '0;
      lane_output_amplitude <= {LANES{AMP_DEFAULT}};
      lane_signal_loss_detect_en <= {LANES{1'b1}};
      lane_deemphasis_code <= '0;
      lane_rx_polarity_swap <= '0;
      lane_tx_polarity_swap <= '0;
      lane_equalizer_code <= {LANES{EQ_MAX_GAIN}};
      lane_eq_max_gain <= {LANES{1'b1}};
      lane_eq_adaptive <= '0;
      lane_eq_reserved <= '0;
    end else begin
      lane_tx_channel_enable <= next_tx_en;
      lane_rx_channel_enable <= next_rx_en;
      lane_tx_rate_divide <= next_tx_rate;
      lane_rx_rate_divide <= next_rx_rate;
      lane_rate_reserved <= next_rate_rsvd;
      lane_output_amplitude <= next_amp;
      lane_signal_loss_detect_en <= next_los;
      lane_deemphasis_code <= next_de;
      lane_rx_polarity_swap <= next_rx_swap;
      lane_tx_polarity_swap <= next_tx_swap;
      lane_equalizer_code <= next_eq;
      lane_eq_max_gain <= next_eq_max;
      lane_eq_adaptive <= next_eq_adapt;
      lane_eq_reserved <= next_eq_rsvd;
    end
  end

  // Checks, lane 0 as the witness lane
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_wr_all_a;
    reg_wr_en && hit_a && all_lanes_write_en;
  endsequence
  sequence s_wr_all_b;
    reg_wr_en && hit_b && all_lanes_write_en;
  endsequence
  sequence s_rd_b_clean;
    reg_rd_en && hit_b && sel_valid && !reg_wr_en;
  endsequence

  a_mult_half_step: assert property ( // see R01
    slow_pll_multiplier_code == 4'h7 |=> pll_multiplier_halves == 8'h19
      && !pll_multiplier_reserved)
    else $error("Multiplier code 0111 not decoded as 12.5x");
  a_mult_rsvd_flag: assert property ( // see R01
    slow_pll_multiplier_code == 4'hB |=> pll_multiplier_reserved)
    else $error("Reserved multiplier code not flagged");
  a_amp_follows_wr: assert property ( // see R02
    s_wr_all_a |-> ##2 lane_output_amplitude[2:0] == $past(reg_wdata[AMP_MSB:AMP_LSB], 2))
    else $error("Amplitude did not follow write");
  a_los_follows_wr: assert property ( // see R03
    s_wr_all_a |-> ##2 lane_signal_loss_detect_en[0] == $past(reg_wdata[LOS_BIT], 2))
    else $error("Loss detect enable did not follow write");
  a_tx_pd_force: assert property ( // see R04
    (!lane_power_down_n[0] || global_power_down) |=> !lane_tx_channel_enable[0])
    else $error("Transmit lane enabled while powered down");
  a_tx_en_follow: assert property ( // see R04
    s_wr_all_a ##1 (lane_power_down_n[0] && !global_power_down)
      |=> lane_tx_channel_enable[0] == $past(reg_wdata[TXEN_BIT], 2))
    else $error("Transmit enable did not follow write");
  a_rx_pd_force: assert property ( // see R05
    (!lane_power_down_n[0] || global_power_down) |=> !lane_rx_channel_enable[0])
    else $error("Receive lane enabled while powered down");
  a_rate_fields: assert property ( // see R06 see R07
    s_wr_all_a |-> ##2 lane_tx_rate_divide[1:0] == $past(reg_wdata[TXRATE_MSB:TXRATE_LSB], 2)
      && lane_rx_rate_divide[1:0] == $past(reg_wdata[RXRATE_MSB:RXRATE_LSB], 2))
    else $error("Rate fields did not follow write");
  a_deemph_follow: assert property ( // see R08
    s_wr_all_a |-> ##2 lane_deemphasis_code[3:0] == $past(reg_wdata[DE_MSB:DE_LSB], 2))
    else $error("De-emphasis did not follow write");
  a_swap_follow: assert property ( // see R09 see R10
    s_wr_all_b |-> ##2 lane_rx_polarity_swap[0] == $past(reg_wdata[RXSWAP_BIT], 2)
      && lane_tx_polarity_swap[0] == $past(reg_wdata[TXSWAP_BIT], 2))
    else $error("Polarity swap did not follow write");
  a_eq_adaptive: assert property ( // see R11
    (s_wr_all_b and reg_wdata[EQ_MSB:EQ_LSB] == EQ_ADAPTIVE)
      |-> ##2 lane_eq_adaptive[0] && !lane_eq_max_gain[0] && !lane_eq_reserved[0])
    else $error("Equalizer code 0001 not adaptive");
  a_rsvd_store: assert property ( // see R12
    s_wr_all_b |=> mem_if.cfg_b[0][RSVD_MSB:RSVD_LSB] == $past(reg_wdata[RSVD_MSB:RSVD_LSB]))
    else $error("Reserved byte not stored");
  a_single_lane_wr: assert property ( // see R13
    reg_wr_en && hit_a && !all_lanes_write_en && lane_select != '0
      |=> $stable(mem_if.cfg_a[0]))
    else $error("Unselected lane changed on write");
  a_read_selected: assert property ( // see R14
    s_rd_b_clean |-> ##2 reg_rd_valid && reg_rdata == $past(sel_b, 2))
    else $error("Read did not return selected lane copy");
endmodule
`default_nettype wire

// ### hw/lsl_lane_mem.sv
// Purpose: Per-lane copies of the two lane configuration words
// Assumes: Caller keeps rd_lane below LANES
// Notes: Read data is registered; a write and read in one cycle reads old data
`timescale 1ns/1ps
`default_nettype none
module lsl_lane_mem #(
  parameter int LANES = lsl_pkg::LANE_CNT
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  lsl_cfg_if.mem cfg
);
  import lsl_pkg::*;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cfg.cfg_a <= {LANES{RST_RATE_ENABLE}};
      cfg.cfg_b <= {LANES{RST_POLARITY_EQ}};
      cfg.rd_data <= '0;
    end else begin
      for (int l = 0; l < LANES; l++) begin
        if (cfg.wr_lane_mask[l] && !cfg.wr_reg) begin
          cfg.cfg_a[l] <= cfg.wr_data;
        end
        if (cfg.wr_lane_mask[l] && cfg.wr_reg) begin
          cfg.cfg_b[l] <= cfg.wr_data;  // see R12
        end
      end
      cfg.rd_data <= cfg.rd_reg ? cfg.cfg_b[cfg.rd_lane] : cfg.cfg_a[cfg.rd_lane];
    end
  end
endmodule
`default_nettype wire

// ### hw/lsl_pkg.sv
// Purpose: Shared constants for the low-speed lane configuration bank
// Assumes: 16-bit management registers with 5-bit register addresses
// Notes: Field positions are bit indices inside each per-lane word
package lsl_pkg;
  localparam int LANE_CNT = 8;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 5;
  localparam int SEL_W = 3;

  localparam logic [ADDR_W-1:0] ADDR_RATE_ENABLE = 5'h07;
  localparam logic [ADDR_W-1:0] ADDR_POLARITY_EQ = 5'h08;

  localparam logic [DATA_W-1:0] RST_RATE_ENABLE = 16'hDD05;
  localparam logic [DATA_W-1:0] RST_POLARITY_EQ = 16'h000D;

  // Rate and enable word
  localparam int AMP_MSB = 14;
  localparam int AMP_LSB = 12;
  localparam int LOS_BIT = 11;
  localparam int TXEN_BIT = 10;
  localparam int TXRATE_MSB = 9;
  localparam int TXRATE_LSB = 8;
  localparam int DE_MSB = 7;
  localparam int DE_LSB = 4;
  localparam int RXEN_BIT = 2;
  localparam int RXRATE_MSB = 1;
  localparam int RXRATE_LSB = 0;

  // Polarity and equalizer word
  localparam int RXSWAP_BIT = 15;
  localparam int TXSWAP_BIT = 14;
  localparam int EQ_MSB = 11;
  localparam int EQ_LSB = 8;
  localparam int RSVD_MSB = 7;
  localparam int RSVD_LSB = 0;
  localparam logic [7:0] RST_RSVD = 8'h0D;

  localparam logic [1:0] RATE_FULL = 2'h0;
  localparam logic [1:0] RATE_HALF = 2'h1;
  localparam logic [1:0] RATE_QUARTER = 2'h2;
  localparam logic [1:0] RATE_RESERVED = 2'h3;
  localparam logic [2:0] AMP_DEFAULT = 3'h5;

  localparam logic [3:0] EQ_MAX_GAIN = 4'h0;
  localparam logic [3:0] EQ_ADAPTIVE = 4'h1;
  localparam logic [3:0] EQ_STEP_FIRST = 4'h8;

  localparam logic [7:0] MULT_RESERVED = 8'h00;
endpackage

// ### test/test_lsl_lane_cfg.sv
// Purpose: Self-checking bench for the low-speed lane configuration bank
// Assumes: Eight lanes; read answers come two cycles after the strobe
// Notes: Driver queues read expectations, a monitor pops them on each answer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin fail_count++; \
  $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module test_lsl_lane_cfg;
  import lsl_pkg::*;
  localparam int LANES = LANE_CNT;
  localparam int HALVES[16] = '{8, 10, 12, 0, 16, 20, 24, 25, 30, 40, 50, 0, 0, 100, 130, 0};
  localparam int AMP_MV[8] = '{190, 380, 560, 710, 850, 950, 1010, 1050};
  localparam int DE_CP[16] = '{0, 476, 952, 1428, 1904, 2380, 2856, 3332, 3808, 4285, 4761,
    5238, 5714, 6190, 6666, 7142};
  localparam int EQ_MHZ[8] = '{365, 275, 195, 140, 105, 75, 55, 50};
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic all_lanes_write_en = 1'b1;
  logic [SEL_W-1:0] lane_select = '0;
  logic global_power_down = 1'b0;
  logic [LANES-1:0] lane_power_down_n = '1;
  logic [3:0] slow_pll_multiplier_code = 4'h5;
  logic [DATA_W-1:0] reg_rdata;
  logic reg_rd_valid, pll_multiplier_reserved;
  logic [7:0] pll_multiplier_halves;
  logic [LANES-1:0] lane_tx_channel_enable, lane_rx_channel_enable, lane_rate_reserved;
  logic [LANES-1:0] lane_signal_loss_detect_en, lane_rx_polarity_swap, lane_tx_polarity_swap;
  logic [LANES-1:0] lane_eq_max_gain, lane_eq_adaptive, lane_eq_reserved;
  logic [2*LANES-1:0] lane_tx_rate_divide, lane_rx_rate_divide;
  logic [3*LANES-1:0] lane_output_amplitude;
  logic [4*LANES-1:0] lane_deemphasis_code, lane_equalizer_code;
  logic [10:0] sel_amplitude_mv;
  logic [12:0] sel_deemph_centipct;
  logic [8:0] sel_eq_zero_mhz;
  logic [DATA_W-1:0] mdl_a [LANES];
  logic [DATA_W-1:0] mdl_b [LANES];
  logic [DATA_W-1:0] exp_q [$];
  logic [DATA_W-1:0] mon_exp;
  logic [LANES-1:0] exp_tx, exp_rx;
  logic [31:0] seed = 32'h0000001B;
  logic [3:0] c;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;

  lsl_lane_cfg #(.LANES(LANES)) u_dut (
    .ref_clk, .reset_n, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata, .reg_rdata,
    .reg_rd_valid, .all_lanes_write_en, .lane_select, .global_power_down,
    .lane_power_down_n, .slow_pll_multiplier_code, .pll_multiplier_halves,
    .pll_multiplier_reserved, .lane_tx_channel_enable, .lane_rx_channel_enable,
    .lane_tx_rate_divide, .lane_rx_rate_divide, .lane_rate_reserved, .lane_output_amplitude,
    .lane_signal_loss_detect_en, .lane_deemphasis_code, .lane_rx_polarity_swap,
    .lane_tx_polarity_swap, .lane_equalizer_code, .lane_eq_max_gain, .lane_eq_adaptive,
    .lane_eq_reserved, .sel_amplitude_mv, .sel_deemph_centipct, .sel_eq_zero_mhz
  );

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Model follows the same lane mask the write should use
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    input logic all, input logic [SEL_W-1:0] ln);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    all_lanes_write_en = all;
    lane_select = ln;
    reg_wr_en = 1'b1;
    @(negedge ref_clk);
    reg_wr_en = 1'b0;
    for (int l = 0; l < LANES; l++) begin
      if (all || l == ln) begin
        if (a == ADDR_RATE_ENABLE) mdl_a[l] = d;
        if (a == ADDR_POLARITY_EQ) mdl_b[l] = d;
      end
    end
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [SEL_W-1:0] ln);
    @(negedge ref_clk);
    reg_addr = a;
    lane_select = ln;
    reg_rd_en = 1'b1;
    exp_q.push_back(a == ADDR_RATE_ENABLE ? mdl_a[ln] : a == ADDR_POLARITY_EQ ? mdl_b[ln] : '0);
    @(negedge ref_clk);
    reg_rd_en = 1'b0;
  endtask

  task automatic settle();
    repeat (2) @(negedge ref_clk);
  endtask

  // Outputs are registered, so negedge sees them settled
  always @(negedge ref_clk) begin
    if (reset_n === 1'b1 && reg_rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        `CHK("unrequested answer", 1'b0, 1'b1)
      end else begin
        mon_exp = exp_q.pop_front();
        `CHK("read data", mon_exp, reg_rdata)
      end
    end
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      close_out();
    end
  end

  initial begin
    for (int l = 0; l < LANES; l++) begin
      mdl_a[l] = RST_RATE_ENABLE;
      mdl_b[l] = RST_POLARITY_EQ;
    end
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk) reset_n = 1'b1;
    settle();
    `CHK("tx rate", {LANES{RATE_HALF}}, lane_tx_rate_divide)
    `CHK("rx rate", {LANES{RATE_HALF}}, lane_rx_rate_divide)
    `CHK("amplitude", {LANES{AMP_DEFAULT}}, lane_output_amplitude)
    `CHK("los en", {LANES{1'b1}}, lane_signal_loss_detect_en)
    `CHK("deemph", {(4*LANES){1'b0}}, lane_deemphasis_code)
    `CHK("swaps", {(2*LANES){1'b0}}, {lane_rx_polarity_swap, lane_tx_polarity_swap})
    `CHK("eq max", {LANES{1'b1}}, lane_eq_max_gain)
    `CHK("enables", {(2*LANES){1'b1}}, {lane_tx_channel_enable, lane_rx_channel_enable})
    for (int l = 0; l < LANES; l++) begin
      rd(ADDR_RATE_ENABLE, 3'(l));
      rd(ADDR_POLARITY_EQ, 3'(l));
    end
    rd(5'h09, 3'h0);
    // Every code through the decoders, lane chosen by low bits
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      slow_pll_multiplier_code = c;
      wr(ADDR_RATE_ENABLE, {1'b0, c[2:0], 2'b11, c[1:0], c, 2'b01, c[1:0]}, 1'b1, c[2:0]);
      wr(ADDR_POLARITY_EQ, {4'h0, c, 8'h0D}, 1'b1, c[2:0]);
      settle();
      `CHK("pll halves", 8'(HALVES[i]), pll_multiplier_halves)
      `CHK("pll rsvd", (c inside {4'h3, 4'hB, 4'hC, 4'hF}), pll_multiplier_reserved)
      `CHK("amp mv", 11'(AMP_MV[i % 8]), sel_amplitude_mv)
      `CHK("lane amp", c[2:0], lane_output_amplitude[3*(i%8)+:3])
      `CHK("deemph pct", 13'(DE_CP[i]), sel_deemph_centipct)
      `CHK("lane de", c, lane_deemphasis_code[4*(i%8)+:4])
      `CHK("eq mhz", 9'(i >= 8 ? EQ_MHZ[i-8] : 0), sel_eq_zero_mhz)
      `CHK("eq flags", {i == 0, i == 1 || i >= 8, i >= 2 && i <= 7},
           {lane_eq_max_gain[i%8], lane_eq_adaptive[i%8], lane_eq_reserved[i%8]})
      `CHK("tx rate", c[1:0], lane_tx_rate_divide[2*(i%8)+:2])
      `CHK("rx rate", c[1:0], lane_rx_rate_divide[2*(i%8)+:2])
      `CHK("rate rsvd", c[1:0] == RATE_RESERVED, lane_rate_reserved[i%8])
    end
    for (int l = 0; l < LANES; l++) begin
      wr(ADDR_RATE_ENABLE, 16'(rnd()) | 16'h0404, 1'b0, 3'(l));
      wr(ADDR_POLARITY_EQ, 16'(rnd()), 1'b0, 3'(l));
    end
    wr(5'h1F, 16'hFFFF, 1'b1, 3'h0);
    for (int l = 0; l < LANES; l++) begin
      rd(ADDR_RATE_ENABLE, 3'(l));
      rd(ADDR_POLARITY_EQ, 3'(l));
    end
    settle();
    for (int l = 0; l < LANES; l++) begin
      `CHK("rx swap", mdl_b[l][RXSWAP_BIT], lane_rx_polarity_swap[l])
      `CHK("tx swap", mdl_b[l][TXSWAP_BIT], lane_tx_polarity_swap[l])
      `CHK("eq code", mdl_b[l][EQ_MSB:EQ_LSB], lane_equalizer_code[4*l+:4])
      `CHK("los en", mdl_a[l][LOS_BIT], lane_signal_loss_detect_en[l])
    end
    // Pins gate the enables only; stored bits must read back intact
    for (int p = 0; p < 3; p++) begin
      lane_power_down_n = 8'(rnd());
      global_power_down = (p == 2);
      settle();
      for (int l = 0; l < LANES; l++) begin
        exp_tx[l] = mdl_a[l][TXEN_BIT] & lane_power_down_n[l] & ~global_power_down;
        exp_rx[l] = mdl_a[l][RXEN_BIT] & lane_power_down_n[l] & ~global_power_down;
      end
      `CHK("tx enable", exp_tx, lane_tx_channel_enable)
      `CHK("rx enable", exp_rx, lane_rx_channel_enable)
      rd(ADDR_RATE_ENABLE, 3'(p));
    end
    repeat (4) @(negedge ref_clk);
    `CHK("pending reads", 0, exp_q.size())
    close_out();
  end
endmodule
`default_nettype wire
